// file: hw/fbc_regs.vh
// Command codes, unlock addresses and timing for the flash command host.
// Assumes a word or byte wide parallel flash with the unlock command set.
`ifndef FBC_REGS_VH
`define FBC_REGS_VH
// Data codes, same in both bus widths
`define FBC_D_UNLOCK1 8'hAA
`define FBC_D_UNLOCK2 8'h55
`define FBC_D_BYPASS 8'h20
`define FBC_D_PROGRAM 8'hA0
`define FBC_D_BYP_EXIT1 8'h90
`define FBC_D_BYP_EXIT2 8'h00
`define FBC_D_ERASE_SETUP 8'h80
`define FBC_D_CHIP_ERASE 8'h10
`define FBC_D_BLOCK_ERASE 8'h30
`define FBC_D_SUSPEND 8'hB0
`define FBC_D_RESUME 8'h30
`define FBC_D_RESET 8'hF0
// Unlock addresses, word mode then byte mode; byte mode counts the extra low line
`define FBC_A_W_FIRST 12'h555
`define FBC_A_W_SECOND 12'h2AA
`define FBC_A_B_FIRST 12'hAAA
`define FBC_A_B_SECOND 12'h555
// Command opcodes on the user port
`define FBC_OP_BYP_ENTER 4'h1
`define FBC_OP_BYP_PROG 4'h2
`define FBC_OP_BYP_EXIT 4'h3
`define FBC_OP_CHIP_ERASE 4'h4
`define FBC_OP_BLOCK_ERASE 4'h5
`define FBC_OP_BLOCK_ADD 4'h6
`define FBC_OP_SUSPEND 4'h7
`define FBC_OP_RESUME 4'h8
`define FBC_OP_RESET 4'h9
`define FBC_OP_RESET_LONG 4'hA
// Status bit positions
`define FBC_SR_TIMER 3
// Block select window in us, clock in MHz
`define FBC_BLOCK_WIN_US 50
`define FBC_CLK_MHZ 100
`endif

// file: hw/fbc_seq_rom.v
// Command sequence table: address and data of each bus write of a command.
// Assumes the caller registers its step index; data come out of a register.
`timescale 1ns/1ns
`include "fbc_regs.vh"
module fbc_seq_rom (
  input wire i_clock,
  input wire [3:0] i_op,
  input wire [2:0] i_step,
  input wire i_byte_mode,
  output reg [11:0] o_addr,
  output reg [7:0] o_data,
  output reg o_any_addr
);
  reg [11:0] next_addr;
  reg [7:0] next_data;
  reg next_any;
  reg [11:0] a1;
  reg [11:0] a2;
  // Look up one write of one command
  always @* begin
    a1 = i_byte_mode ? `FBC_A_B_FIRST : `FBC_A_W_FIRST;
    a2 = i_byte_mode ? `FBC_A_B_SECOND : `FBC_A_W_SECOND;
    next_any = 1'b0;
    next_addr = a1;
    next_data = `FBC_D_UNLOCK1;
    case (i_op)
      `FBC_OP_BYP_PROG: begin
        next_any = 1'b1;
        next_data = `FBC_D_PROGRAM;
      end
      `FBC_OP_BYP_EXIT: begin
        next_any = 1'b1;
        next_data = (i_step == 3'h0) ? `FBC_D_BYP_EXIT1 : `FBC_D_BYP_EXIT2;
      end
      `FBC_OP_SUSPEND: begin
        next_any = 1'b1;
        next_data = `FBC_D_SUSPEND;
      end
      `FBC_OP_RESUME: begin
        next_any = 1'b1;
        next_data = `FBC_D_RESUME;
      end
      `FBC_OP_RESET: begin
        next_any = 1'b1;
        next_data = `FBC_D_RESET;
      end
      default: begin
        case (i_step)
          3'h0, 3'h3: begin
            next_addr = a1;
            next_data = `FBC_D_UNLOCK1;
          end
          3'h1, 3'h4: begin
            next_addr = a2;
            next_data = `FBC_D_UNLOCK2;
          end
          3'h2: begin
            next_addr = a1;
            if (i_op == `FBC_OP_BYP_ENTER)
              next_data = `FBC_D_BYPASS;
            else if (i_op == `FBC_OP_RESET_LONG) begin
              next_any = 1'b1;
              next_data = `FBC_D_RESET;
            end else
              next_data = `FBC_D_ERASE_SETUP;
          end
          default: begin
            next_addr = a1;
            next_data = (i_op == `FBC_OP_CHIP_ERASE) ? `FBC_D_CHIP_ERASE
                                                     : `FBC_D_BLOCK_ERASE;
          end
        endcase
      end
    endcase
  end
  // Registered table output
  always @(posedge i_clock) begin
    o_addr <= next_addr;
    o_data <= next_data;
    o_any_addr <= next_any;
  end
endmodule

// file: hw/fbc_host.v
// Host controller driving flash bus writes for bypass, erase and suspend.
// Assumes a device that latches on the rising edge of the write strobe.
`timescale 1ns/1ns
`include "fbc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module fbc_host #(
  parameter AW = 17,
  parameter DW = 16,
  parameter WIN_CYCLES = `FBC_BLOCK_WIN_US * `FBC_CLK_MHZ,
  parameter STROBE = 3
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_byte_mode,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_op,
  input wire [AW-1:0] i_cmd_addr,
  input wire [DW-1:0] i_cmd_data,
  input wire i_dev_ready,
  input wire [DW-1:0] i_dq_in,
  output wire o_cmd_ready,
  output reg o_cmd_done,
  output reg o_in_bypass,
  output reg o_erasing,
  output reg o_suspended,
  output reg o_block_window,
  output reg [AW-1:0] o_addr,
  output reg [DW-1:0] o_dq_out,
  output reg o_dq_oe,
  output reg o_we_n,
  output reg o_ce_n,
  output reg o_oe_n
);
  localparam S_IDLE = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_PULSE = 4'b0100;
  localparam S_GAP = 4'b1000;
  reg [3:0] state;
  reg [3:0] op;
  reg [2:0] step;
  reg [7:0] tcnt;
  reg [31:0] win;
  reg sel_open;
  reg [AW-1:0] uaddr;
  reg [DW-1:0] udata;
  wire [11:0] rom_addr;
  wire [7:0] rom_data;
  wire rom_any;
  reg [2:0] last_step;
  reg legal;

  fbc_seq_rom u_rom (
    .i_clock(i_clock),
    .i_op(op),
    .i_step(step),
    .i_byte_mode(i_byte_mode),
    .o_addr(rom_addr),
    .o_data(rom_data),
    .o_any_addr(rom_any)
  );

  // Number of writes minus one for a command
  function [2:0] fbc_len;
    input [3:0] f_op;
    begin
      case (f_op)
        `FBC_OP_BYP_PROG, `FBC_OP_BYP_EXIT: fbc_len = 3'h1;
        `FBC_OP_BYP_ENTER, `FBC_OP_RESET_LONG: fbc_len = 3'h2;
        `FBC_OP_CHIP_ERASE, `FBC_OP_BLOCK_ERASE: fbc_len = 3'h5;
        default: fbc_len = 3'h0;
      endcase
    end
  endfunction

  // Which commands the device accepts in the present mode
  always @* begin
    legal = 1'b0;
    if (o_in_bypass)
      legal = (i_cmd_op == `FBC_OP_BYP_PROG) || (i_cmd_op == `FBC_OP_BYP_EXIT) ||
              (i_cmd_op == `FBC_OP_RESET);
    else if (o_erasing)
      legal = (i_cmd_op == `FBC_OP_SUSPEND) || (i_cmd_op == `FBC_OP_RESET) ||
              (i_cmd_op == `FBC_OP_BLOCK_ADD && sel_open);
    else if (o_suspended)
      legal = (i_cmd_op == `FBC_OP_RESUME) || (i_cmd_op == `FBC_OP_RESET) ||
              (i_cmd_op == `FBC_OP_RESET_LONG);
    else
      legal = (i_cmd_op == `FBC_OP_BYP_ENTER) || (i_cmd_op == `FBC_OP_CHIP_ERASE) ||
              (i_cmd_op == `FBC_OP_BLOCK_ERASE) || (i_cmd_op == `FBC_OP_RESET) ||
              (i_cmd_op == `FBC_OP_RESET_LONG);
  end

  // Busy program or chip erase holds commands off; the done cycle ends a request
  assign o_cmd_ready = (state == S_IDLE) && !o_cmd_done && (i_dev_ready || o_erasing) &&
                       !(o_erasing && !o_block_window && op == `FBC_OP_CHIP_ERASE);

  // Write sequencer
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= S_IDLE;
      op <= 4'h0;
      step <= 3'h0;
      last_step <= 3'h0;
      tcnt <= 8'h00;
      uaddr <= {AW{1'b0}};
      udata <= {DW{1'b0}};
      o_cmd_done <= 1'b0;
      o_addr <= {AW{1'b0}};
      o_dq_out <= {DW{1'b0}};
      o_dq_oe <= 1'b0;
      o_we_n <= 1'b1;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
    end else begin
      o_cmd_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_cmd_valid && o_cmd_ready && legal) begin
            op <= (i_cmd_op == `FBC_OP_BLOCK_ADD) ? `FBC_OP_BLOCK_ERASE : i_cmd_op;
            step <= (i_cmd_op == `FBC_OP_BLOCK_ADD) ? 3'h5 : 3'h0;
            last_step <= fbc_len(i_cmd_op == `FBC_OP_BLOCK_ADD ? `FBC_OP_BLOCK_ERASE
                                                                : i_cmd_op);
            uaddr <= i_cmd_addr;
            udata <= i_cmd_data;
            tcnt <= 8'h00;
            state <= S_SETUP;
          end else if (i_cmd_valid && o_cmd_ready)
            o_cmd_done <= 1'b1; // Refused command completes with no bus write
        end
        S_SETUP: begin
          // The table answers a cycle after op and step move, so wait one cycle
          if (tcnt == 8'h00)
            tcnt <= 8'h01;
          else begin
            // Upper data lines are don't care, so drive zero there
            o_dq_out <= {{(DW-8){1'b0}}, rom_data};
            o_addr <= rom_any ? uaddr : {{(AW-12){1'b0}}, rom_addr};
            if (op == `FBC_OP_BYP_PROG && step == 3'h1) begin
              o_addr <= uaddr;
              o_dq_out <= udata;
            end
            if (op == `FBC_OP_BLOCK_ERASE && step == 3'h5)
              o_addr <= uaddr;
            o_dq_oe <= 1'b1;
            o_ce_n <= 1'b0;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b0;
            tcnt <= 8'h00;
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          tcnt <= tcnt + 8'h01;
          if (tcnt == STROBE[7:0]) begin
            o_we_n <= 1'b1; // Device latches on this rising edge
            tcnt <= 8'h00;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          tcnt <= tcnt + 8'h01;
          if (tcnt == STROBE[7:0]) begin
            o_ce_n <= 1'b1;
            o_dq_oe <= 1'b0;
            if (step == last_step) begin
              o_cmd_done <= 1'b1;
              state <= S_IDLE;
            end else begin
              step <= step + 3'h1;
              tcnt <= 8'h00;
              state <= S_SETUP;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Mode tracking mirrors the device command state
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_in_bypass <= 1'b0;
      o_erasing <= 1'b0;
      o_suspended <= 1'b0;
      o_block_window <= 1'b0;
      sel_open <= 1'b0;
      win <= 32'h0;
    end else begin
      if (o_block_window) begin
        win <= win - 32'h1;
        if (win == 32'h0) begin
          o_block_window <= 1'b0;
          sel_open <= 1'b0;
        end
      end
      if (o_erasing && !o_block_window && i_dev_ready && state == S_IDLE)
        o_erasing <= 1'b0;
      if (state == S_GAP && tcnt == STROBE[7:0] && step == last_step) begin
        case (op)
          `FBC_OP_BYP_ENTER: o_in_bypass <= 1'b1;
          `FBC_OP_BYP_EXIT: o_in_bypass <= 1'b0;
          `FBC_OP_CHIP_ERASE: o_erasing <= 1'b1;
          `FBC_OP_BLOCK_ERASE: begin
            o_erasing <= 1'b1;
            if (!o_suspended) begin
              o_block_window <= 1'b1;
              sel_open <= 1'b1;
              win <= WIN_CYCLES - 1;
            end
          end
          `FBC_OP_SUSPEND: begin
            o_erasing <= 1'b0;
            o_suspended <= 1'b1;
            o_block_window <= 1'b0;
            sel_open <= 1'b0;
          end
          `FBC_OP_RESUME: o_erasing <= 1'b1;
          `FBC_OP_RESET: begin
            o_erasing <= 1'b0;
            if (!o_suspended)
              o_block_window <= 1'b0;
          end
          default: o_block_window <= o_block_window;
        endcase
        if (op == `FBC_OP_RESUME)
          o_suspended <= 1'b0;
      end
    end
  end
endmodule

// file: test/fbc_flash_model.sv
// Behavioural flash device on the far side of the host's write bus.
// Latches a write when the strobe rises with select low; drives ready.
`timescale 1ns/1ns
module fbc_flash_model #(
  parameter BUSY = 60
) (
  input wire i_clock,
  input wire [16:0] i_addr,
  input wire [15:0] i_dq,
  input wire i_we_n,
  input wire i_ce_n,
  output reg o_ready,
  output reg [15:0] o_dq,
  output reg o_wr,
  output reg [16:0] o_wr_addr,
  output reg [15:0] o_wr_data
);
  reg we_q = 1'b1;
  reg prog = 1'b0;
  reg susp = 1'b0;
  integer cnt = 0;
  // Idle values at power up
  initial begin
    o_ready = 1'b1;
    o_dq = 16'h5A5A;
    o_wr = 1'b0;
  end
  // Busy countdown, write capture and command decode
  always @(posedge i_clock) begin
    we_q <= i_we_n;
    o_wr <= 1'b0;
    o_dq <= ~o_dq; // Unowned bus shows a moving pattern
    if (cnt > 0) cnt <= cnt - 1;
    else if (!susp) o_ready <= 1'b1;
    if (i_we_n && !we_q && !i_ce_n) begin
      o_wr <= 1'b1;
      o_wr_addr <= i_addr;
      o_wr_data <= i_dq;
      prog <= !prog && i_dq[7:0] == 8'hA0;
      if (prog || i_dq[7:0] == 8'h10 || i_dq[7:0] == 8'h30) begin
        o_ready <= 1'b0;
        cnt <= BUSY;
        susp <= 1'b0;
      end else if (i_dq[7:0] == 8'hB0 || i_dq[7:0] == 8'hF0) begin
        o_ready <= 1'b1;
        cnt <= 0;
        susp <= susp || i_dq[7:0] == 8'hB0;
      end
    end
  end
endmodule

// file: test/fbc_host_asserts.sv
// Checker on the flash host ports: strobes, holds and handshake.
// Bound into every fbc_host instance.
`timescale 1ns/1ns
module fbc_host_asserts #(
  parameter AW = 17,
  parameter DW = 16
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_op,
  input wire i_dev_ready,
  input wire o_cmd_ready,
  input wire o_cmd_done,
  input wire o_in_bypass,
  input wire o_erasing,
  input wire o_suspended,
  input wire o_block_window,
  input wire [AW-1:0] o_addr,
  input wire [DW-1:0] o_dq_out,
  input wire o_dq_oe,
  input wire o_we_n,
  input wire o_ce_n,
  input wire o_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Pin and handshake relations
  property p_sel; !o_we_n |-> !o_ce_n && o_dq_oe && o_oe_n; endproperty
  a_sel: assert property (p_sel) else $error("strobe outside a selected write");
  property p_pulse; $fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width wrong");
  property p_hold; !o_we_n && !$past(o_we_n) |-> $stable(o_addr) && $stable(o_dq_out);
  endproperty
  a_hold: assert property (p_hold) else $error("write lines moved");
  property p_done; o_cmd_done |=> !o_cmd_done; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_refuse; o_in_bypass && i_cmd_valid && o_cmd_ready && i_cmd_op == 4'h4
    |=> o_we_n throughout (##[0:2] o_cmd_done); endproperty
  a_refuse: assert property (p_refuse) else $error("erase sent in bypass");
  property p_busy; o_in_bypass && !i_dev_ready && !$past(i_dev_ready) |-> !o_cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while program busy");
  property p_resume; $fell(o_suspended) |-> !o_block_window [*2]; endproperty
  a_resume: assert property (p_resume) else $error("window open after resume");
  property p_rst; disable iff (1'b0) i_sys_rst |=> o_we_n && o_ce_n && !o_dq_oe
    && !o_in_bypass && !o_erasing; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
endmodule
bind fbc_host fbc_host_asserts #(.AW(AW), .DW(DW)) i_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
  .i_dev_ready(i_dev_ready), .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done),
  .o_in_bypass(o_in_bypass), .o_erasing(o_erasing), .o_suspended(o_suspended),
  .o_block_window(o_block_window), .o_addr(o_addr), .o_dq_out(o_dq_out),
  .o_dq_oe(o_dq_oe), .o_we_n(o_we_n), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n));

// file: test/fbc_host_tb.sv
// Testbench of the flash host against the behavioural device.
// Expected bus writes are queued by the bench and compared in order.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module fbc_host_tb;
  reg i_clock = 0, rst = 1, bm = 0, vld = 0;
  reg [3:0] op = 0;
  reg [16:0] addr = 0, ra;
  reg [15:0] data = 0, rd;
  wire rdy, done, byp, ers, sus, win, dq_oe, we_n, ce_n, oe_n, dev_rdy, wr;
  wire [16:0] a_pin, wr_a;
  wire [15:0] dq, dq_in, wr_d;
  integer error_cnt = 0, compares = 0, cyc = 0, n, k;
  reg [34:0] exq[$];
  reg [32:0] got[$];
  always #5 i_clock = ~i_clock;
  fbc_host #(.WIN_CYCLES(50), .STROBE(3)) i_dut (.i_clock(i_clock), .i_sys_rst(rst),
    .i_byte_mode(bm), .i_cmd_valid(vld), .i_cmd_op(op), .i_cmd_addr(addr),
    .i_cmd_data(data), .i_dev_ready(dev_rdy), .i_dq_in(dq_in), .o_cmd_ready(rdy),
    .o_cmd_done(done), .o_in_bypass(byp), .o_erasing(ers), .o_suspended(sus),
    .o_block_window(win), .o_addr(a_pin), .o_dq_out(dq), .o_dq_oe(dq_oe),
    .o_we_n(we_n), .o_ce_n(ce_n), .o_oe_n(oe_n));
  fbc_flash_model #(.BUSY(60)) i_mem (.i_clock(i_clock), .i_addr(a_pin), .i_dq(dq),
    .i_we_n(we_n), .i_ce_n(ce_n), .o_ready(dev_rdy), .o_dq(dq_in), .o_wr(wr),
    .o_wr_addr(wr_a), .o_wr_data(wr_d));
  // Collect device writes and guard against a hang
  always @(posedge i_clock) begin
    if (wr) got.push_back({wr_a, wr_d});
    cyc = cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      summarize;
    end
  end
  function [16:0] fa(input b); fa = b ? 17'h00AAA : 17'h00555; endfunction
  function [16:0] sa(input b); sa = b ? 17'h00555 : 17'h002AA; endfunction
  // Compare mask: 0 command, 1 full, 2 data only, 3 full address
  function [32:0] msk(input [1:0] k);
    msk = (k == 2'h1) ? {33{1'b1}} :
      {(k == 2'h0) ? 17'h00FFF : (k == 2'h3) ? 17'h1FFFF : 17'h00000, 16'h00FF};
  endfunction
  task ex(input [1:0] k, input [16:0] a, input [15:0] d); exq.push_back({k, a, d}); endtask
  task unl; begin ex(0, fa(bm), 16'h00AA); ex(0, sa(bm), 16'h0055); end endtask
  task chk;
    integer i;
    begin
      `CHK(got.size(), exq.size())
      for (i = 0; i < exq.size() && i < got.size(); i++)
        `CHK(got[i] & msk(exq[i][34:33]), exq[i][32:0] & msk(exq[i][34:33]))
      got.delete();
      exq.delete();
    end
  endtask
  task cmd(input [3:0] o, input [16:0] a, input [15:0] d);
    begin
      @(posedge i_clock);
      vld <= 1;
      op <= o;
      addr <= a;
      data <= d;
      n = 0;
      do begin @(posedge i_clock); n++; end while (done !== 1'b1 && n < 400);
      `CHK(done, 1'b1)
      vld <= 0;
      repeat (2) @(posedge i_clock);
    end
  endtask
  task wait_idle; for (n = 0; ers !== 1'b0 && n < 1000; n++) @(posedge i_clock); endtask
  task summarize;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    n = $urandom(15653);
    repeat (16) @(posedge i_clock);
    rst <= 0;
    @(posedge i_clock);
    #1 `CHK({we_n, ce_n, oe_n, dq_oe}, 4'hE)
    cmd(1, 0, 0); unl; ex(0, fa(0), 16'h0020); chk;
    `CHK(byp, 1'b1)
    for (k = 0; k < 2; k++) begin
      ra = $urandom;
      rd = $urandom;
      cmd(2, ra, rd); ex(2, 0, 16'h00A0); ex(1, ra, rd);
    end
    chk;
    cmd(4, 0, 0); chk;
    `CHK(byp, 1'b1)
    cmd(3, 0, 0); ex(2, 0, 16'h0090); ex(2, 0, 16'h0000); chk;
    `CHK(byp, 1'b0)
    cmd(2, 0, 0); cmd(15, 0, 0); chk;
    bm <= 1;
    cmd(4, 0, 0); unl; ex(0, fa(1), 16'h0080); unl; ex(0, fa(1), 16'h0010); chk;
    `CHK(ers, 1'b1)
    wait_idle; `CHK(ers, 1'b0)
    bm <= 0;
    ra = $urandom;
    cmd(5, ra, 0); unl; ex(0, fa(0), 16'h0080); unl; ex(3, ra, 16'h0030);
    ra = $urandom;
    cmd(6, ra, 0); ex(3, ra, 16'h0030); chk;
    `CHK(win, 1'b1)
    `CHK(ers, 1'b1)
    cmd(4, 0, 0); chk;
    cmd(7, 0, 0); ex(2, 0, 16'h00B0); `CHK(sus, 1'b1)
    cmd(9, 0, 0); ex(2, 0, 16'h00F0); `CHK(sus, 1'b1)
    cmd(8, 0, 0); ex(2, 0, 16'h0030); chk;
    `CHK(win, 1'b0)
    wait_idle; `CHK(ers, 1'b0)
    for (k = 0; k < 2; k++) begin
      bm <= k[0];
      cmd(9, 0, 0); ex(2, 0, 16'h00F0);
      cmd(10, 0, 0); unl; ex(2, 0, 16'h00F0);
    end
    chk;
    summarize;
  end
endmodule
